// ===== core/ssu_pkg.sv
// ============================================================
// shared constants and types for the sigma/sum unit
package ssu_pkg;

    // word width of the hash helpers
    localparam int WORD_W = 32;
    // register width for each base
    localparam int NARROW_XLEN = 32;
    localparam int WIDE_XLEN = 64;

    // ============================================================
    // rotation and shift amounts, 256 variant
    localparam int SIG0_ROT_A = 7;
    localparam int SIG0_ROT_B = 18;
    localparam int SIG0_SHR = 3;
    localparam int SIG1_ROT_A = 17;
    localparam int SIG1_ROT_B = 19;
    localparam int SIG1_SHR = 10;
    localparam int SUM0_ROT_A = 2;
    localparam int SUM0_ROT_B = 13;
    localparam int SUM0_ROT_C = 22;
    localparam int SUM1_ROT_A = 6;
    localparam int SUM1_ROT_B = 11;
    localparam int SUM1_ROT_C = 25;

    // ============================================================
    // 512 variant sigma0 amounts, applied across two words
    localparam int WSIG0_ROT_A = 1;
    localparam int WSIG0_ROT_B = 8;
    localparam int WSIG0_SHR = 7;

    // ============================================================
    // instruction field values
    localparam logic [6:0] OPC_IMM = 7'h13;
    localparam logic [6:0] OPC_REG = 7'h33;
    localparam logic [2:0] F3_UNARY = 3'h1;
    localparam logic [2:0] F3_BINARY = 3'h0;
    localparam logic [6:0] F7_UNARY = 7'h08;
    localparam logic [4:0] SEL_SUM0 = 5'h00;
    localparam logic [4:0] SEL_SUM1 = 5'h01;
    localparam logic [4:0] SEL_SIG0 = 5'h02;
    localparam logic [4:0] SEL_SIG1 = 5'h03;
    localparam logic [6:0] F7_WSIG0_HI = 7'h2E;
    localparam logic [6:0] F7_WSIG0_LO = 7'h2A;

    // fixed latency in cycles, issue to result
    localparam int LATENCY = 1;

    // decoded operation
    typedef enum logic [2:0] {
        SSU_OP_NONE = 3'b000,
        SSU_OP_SIG0 = 3'b001,
        SSU_OP_SIG1 = 3'b010,
        SSU_OP_SUM0 = 3'b011,
        SSU_OP_SUM1 = 3'b100,
        SSU_OP_WHI = 3'b101,
        SSU_OP_WLO = 3'b110
    } ssu_op_t;

    // instruction word split into its fields
    typedef struct packed {
        logic [6:0] funct7;
        logic [4:0] src2_field;
        logic [4:0] src1_field;
        logic [2:0] funct3;
        logic [4:0] dest_field;
        logic [6:0] opcode;
    } ssu_insn_t;

endpackage

// ===== core/ssu_unit.sv
`timescale 1ns/1ps
module ssu_unit #(
    parameter int XLEN = ssu_pkg::NARROW_XLEN
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire ssu_pkg::ssu_insn_t issue_insn,
    input wire logic [XLEN-1:0] first_source_reg,
    input wire logic [XLEN-1:0] second_source_reg,
    output logic result_valid,
    output logic [XLEN-1:0] result_data,
    output logic [4:0] result_dest,
    output logic not_claimed
);

    // ============================================================
    // helpers

    // rotate a word right by a fixed amount
    function automatic logic [31:0] rotate_right_word(
        input logic [31:0] w,
        input int unsigned n
    );
        return (w >> n) | (w << (ssu_pkg::WORD_W - n));
    endfunction

    // ============================================================
    // operand words
    logic [31:0] src1_word; // low word of first source
    logic [31:0] src2_word; // low word of second source
    logic narrow_base; // half ops only exist here

    assign src1_word = first_source_reg[31:0];
    assign src2_word = second_source_reg[31:0];
    assign narrow_base = (XLEN == ssu_pkg::NARROW_XLEN);

    // ============================================================
    // decode
    ssu_pkg::ssu_op_t dec_op; // matched operation

    // fixed field compare, no data dependence
    always_comb begin
        dec_op = ssu_pkg::SSU_OP_NONE;
        // single-source word ops, both bases
        if (issue_insn.opcode == ssu_pkg::OPC_IMM &&
            issue_insn.funct3 == ssu_pkg::F3_UNARY &&
            issue_insn.funct7 == ssu_pkg::F7_UNARY) begin
            unique case (issue_insn.src2_field)
                ssu_pkg::SEL_SIG0: dec_op = ssu_pkg::SSU_OP_SIG0;
                ssu_pkg::SEL_SIG1: dec_op = ssu_pkg::SSU_OP_SIG1;
                ssu_pkg::SEL_SUM0: dec_op = ssu_pkg::SSU_OP_SUM0;
                ssu_pkg::SEL_SUM1: dec_op = ssu_pkg::SSU_OP_SUM1;
                default: dec_op = ssu_pkg::SSU_OP_NONE;
            endcase
        end
        // two-source half ops, narrow base only
        else if (narrow_base &&
                 issue_insn.opcode == ssu_pkg::OPC_REG &&
                 issue_insn.funct3 == ssu_pkg::F3_BINARY) begin
            if (issue_insn.funct7 == ssu_pkg::F7_WSIG0_HI) begin
                dec_op = ssu_pkg::SSU_OP_WHI;
            end
            else if (issue_insn.funct7 == ssu_pkg::F7_WSIG0_LO) begin
                dec_op = ssu_pkg::SSU_OP_WLO;
            end
        end
    end

    // ============================================================
    // datapath: every function is always computed
    logic [31:0] sig0_w; // message schedule sigma0
    logic [31:0] sig1_w; // message schedule sigma1
    logic [31:0] sum0_w; // round sum0
    logic [31:0] sum1_w; // round sum1
    logic [31:0] half_common; // terms shared by both halves
    logic [31:0] upper_half_w; // high word of 512 sigma0
    logic [31:0] lower_half_w; // low word of 512 sigma0
    logic [31:0] word_res; // selected word result

    // 256 variant, same for 224 digest, no mode input
    assign sig0_w = rotate_right_word(src1_word, ssu_pkg::SIG0_ROT_A)
                  ^ rotate_right_word(src1_word, ssu_pkg::SIG0_ROT_B)
                  ^ (src1_word >> ssu_pkg::SIG0_SHR);
    assign sig1_w = rotate_right_word(src1_word, ssu_pkg::SIG1_ROT_A)
                  ^ rotate_right_word(src1_word, ssu_pkg::SIG1_ROT_B)
                  ^ (src1_word >> ssu_pkg::SIG1_SHR);
    // round sum0
    assign sum0_w = rotate_right_word(src1_word, ssu_pkg::SUM0_ROT_A)
                  ^ rotate_right_word(src1_word, ssu_pkg::SUM0_ROT_B)
                  ^ rotate_right_word(src1_word, ssu_pkg::SUM0_ROT_C);
    // round sum1
    assign sum1_w = rotate_right_word(src1_word, ssu_pkg::SUM1_ROT_A)
                  ^ rotate_right_word(src1_word, ssu_pkg::SUM1_ROT_B)
                  ^ rotate_right_word(src1_word, ssu_pkg::SUM1_ROT_C);

    // left shifts that bring the other word's bits across
    localparam int WSIG0_LSH_A = ssu_pkg::WORD_W - ssu_pkg::WSIG0_ROT_A;
    localparam int WSIG0_LSH_B = ssu_pkg::WORD_W - ssu_pkg::WSIG0_ROT_B;
    localparam int WSIG0_LSH_S = ssu_pkg::WORD_W - ssu_pkg::WSIG0_SHR;

    // first source is the half being produced, second the other half
    assign half_common = (src1_word >> ssu_pkg::WSIG0_ROT_A)
                       ^ (src1_word >> ssu_pkg::WSIG0_SHR)
                       ^ (src1_word >> ssu_pkg::WSIG0_ROT_B)
                       ^ (src2_word << WSIG0_LSH_A)
                       ^ (src2_word << WSIG0_LSH_B);
    // shift right never carries low bits into the high word
    assign upper_half_w = half_common;
    // low word also gets high bits shifted in
    assign lower_half_w = half_common
                        ^ (src2_word << WSIG0_LSH_S);

    // result select
    always_comb begin
        word_res = '0;
        unique case (dec_op)
            ssu_pkg::SSU_OP_SIG0: word_res = sig0_w;
            ssu_pkg::SSU_OP_SIG1: word_res = sig1_w;
            ssu_pkg::SSU_OP_SUM0: word_res = sum0_w;
            ssu_pkg::SSU_OP_SUM1: word_res = sum1_w;
            ssu_pkg::SSU_OP_WHI: word_res = upper_half_w;
            ssu_pkg::SSU_OP_WLO: word_res = lower_half_w;
            default: word_res = '0;
        endcase
    end

    // ============================================================
    // result registers, one cycle for every operation

    // result handshake
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result_valid <= 1'b0;
            not_claimed <= 1'b0;
        end
        else begin
            result_valid <= issue_valid &&
                            dec_op != ssu_pkg::SSU_OP_NONE;
            not_claimed <= issue_valid &&
                           dec_op == ssu_pkg::SSU_OP_NONE;
        end
    end

    // result data, sign extended on the wide base
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result_data <= '0;
            result_dest <= 5'h00;
        end
        else if (issue_valid) begin
            result_data <= XLEN'($signed(word_res));
            result_dest <= issue_insn.dest_field;
        end
    end

    // ============================================================
    // checks

    // reference rotate built another way
    function automatic logic [31:0] ref_ror(
        input logic [31:0] w,
        input int unsigned n
    );
        logic [63:0] t;
        t = {w, w} >> n;
        return t[31:0];
    endfunction

    // reference 64-bit rotate
    function automatic logic [63:0] ref_ror64(
        input logic [63:0] w,
        input int unsigned n
    );
        logic [127:0] t;
        t = {w, w} >> n;
        return t[63:0];
    endfunction

    // reference 512 sigma0
    function automatic logic [63:0] ref_wsig0(input logic [63:0] w);
        return ref_ror64(w, 1) ^ ref_ror64(w, 8) ^ (w >> 7);
    endfunction

    sequence s_issue_op(ssu_pkg::ssu_op_t op);
        issue_valid && dec_op == op;
    endsequence

    property p_sig0;
        @(posedge sys_clk) disable iff (rst)
        s_issue_op(ssu_pkg::SSU_OP_SIG0) |=> result_data[31:0] ==
            (ref_ror($past(src1_word), 7) ^ ref_ror($past(src1_word), 18)
             ^ ($past(src1_word) >> 3));
    endproperty
    a_sig0: assert property (p_sig0) else $error("sigma0 wrong");

    property p_sig1;
        @(posedge sys_clk) disable iff (rst)
        s_issue_op(ssu_pkg::SSU_OP_SIG1) |=> result_data[31:0] ==
            (ref_ror($past(src1_word), 17) ^ ref_ror($past(src1_word), 19)
             ^ ($past(src1_word) >> 10));
    endproperty
    a_sig1: assert property (p_sig1) else $error("sigma1 wrong");

    property p_sum0;
        @(posedge sys_clk) disable iff (rst)
        s_issue_op(ssu_pkg::SSU_OP_SUM0) |=> result_data[31:0] ==
            (ref_ror($past(src1_word), 2) ^ ref_ror($past(src1_word), 13)
             ^ ref_ror($past(src1_word), 22));
    endproperty
    a_sum0: assert property (p_sum0) else $error("sum0 wrong");

    property p_sum1;
        @(posedge sys_clk) disable iff (rst)
        s_issue_op(ssu_pkg::SSU_OP_SUM1) |=> result_data[31:0] ==
            (ref_ror($past(src1_word), 6) ^ ref_ror($past(src1_word), 11)
             ^ ref_ror($past(src1_word), 25));
    endproperty
    a_sum1: assert property (p_sum1) else $error("sum1 wrong");

    property p_sext;
        @(posedge sys_clk) disable iff (rst)
        result_valid |-> result_data == XLEN'($signed(result_data[31:0]));
    endproperty
    a_sext: assert property (p_sext)
        else $error("no sign extension");

    sequence s_any_claimed;
        issue_valid && dec_op != ssu_pkg::SSU_OP_NONE;
    endsequence

    property p_latency;
        @(posedge sys_clk) disable iff (rst)
        s_any_claimed |=> result_valid ##1 !result_valid || $past(issue_valid);
    endproperty
    a_latency: assert property (p_latency)
        else $error("latency varies");

    property p_half_gate;
        @(posedge sys_clk) disable iff (rst)
        (issue_valid && !narrow_base && issue_insn.opcode == ssu_pkg::OPC_REG)
            |=> not_claimed && !result_valid;
    endproperty
    a_half_gate: assert property (p_half_gate)
        else $error("half op on wide");

    property p_wlo;
        @(posedge sys_clk) disable iff (rst)
        s_issue_op(ssu_pkg::SSU_OP_WLO) |=> result_data[31:0] ==
            32'(ref_wsig0({$past(src2_word), $past(src1_word)}));
    endproperty
    a_wlo: assert property (p_wlo)
        else $error("lower half wrong");

    property p_whi;
        @(posedge sys_clk) disable iff (rst)
        s_issue_op(ssu_pkg::SSU_OP_WHI) |=> result_data[31:0] ==
            32'(ref_wsig0({$past(src1_word), $past(src2_word)}) >> 32);
    endproperty
    a_whi: assert property (p_whi)
        else $error("upper half wrong");

    property p_claim_excl;
        @(posedge sys_clk) disable iff (rst)
        issue_valid |=> result_valid != not_claimed;
    endproperty
    a_claim_excl: assert property (p_claim_excl)
        else $error("claim clash");

endmodule

// ===== bench/ssu_issue_model.sv
`timescale 1ns/1ps
// ============================================================
// pipeline side: offers decoded instructions to the unit
module ssu_issue_model #(
    parameter int XLEN = 32
) (
    input wire logic sys_clk,
    output logic issue_valid,
    output ssu_pkg::ssu_insn_t issue_insn,
    output logic [XLEN-1:0] first_source_reg,
    output logic [XLEN-1:0] second_source_reg
);
    // quiet offer at time zero
    initial begin
        issue_valid = 1'b0;
        issue_insn = '0;
        first_source_reg = '0;
        second_source_reg = '0;
    end

    // offer one instruction from the next rising edge on
    task automatic send(input ssu_pkg::ssu_insn_t insn,
            input logic [XLEN-1:0] a, input logic [XLEN-1:0] b);
        @(posedge sys_clk);
        issue_valid <= 1'b1;
        issue_insn <= insn;
        first_source_reg <= a;
        second_source_reg <= b;
    endtask

    // withdraw; operands flip so stale values cannot pass
    task automatic idle();
        @(posedge sys_clk);
        issue_valid <= 1'b0;
        issue_insn <= ~issue_insn;
        first_source_reg <= ~first_source_reg;
        second_source_reg <= ~second_source_reg;
    endtask
endmodule

// ===== bench/tb_sha2_sigma_sum_unit.sv
`timescale 1ns/1ps
// ============================================================
// bench: narrow and wide units, each fed by its own issuer
module tb_sha2_sigma_sum_unit;
    logic sys_clk;
    logic rst;
    int n_errors = 0;
    int checks_done = 0;
    logic n_iv, w_iv, n_rv, w_rv, n_nc, w_nc;
    ssu_pkg::ssu_insn_t n_insn, w_insn;
    logic [31:0] n_a, n_b, n_data;
    logic [63:0] w_a, w_b, w_data;
    logic [4:0] n_dest, w_dest;

    // ============================================================
    // instances
    ssu_issue_model #(.XLEN(32)) i_core (.sys_clk(sys_clk),
        .issue_valid(n_iv), .issue_insn(n_insn),
        .first_source_reg(n_a), .second_source_reg(n_b));
    ssu_unit #(.XLEN(32)) i_dut (.sys_clk(sys_clk), .rst(rst),
        .issue_valid(n_iv), .issue_insn(n_insn),
        .first_source_reg(n_a), .second_source_reg(n_b),
        .result_valid(n_rv), .result_data(n_data),
        .result_dest(n_dest), .not_claimed(n_nc));
    ssu_issue_model #(.XLEN(64)) i_core_w (.sys_clk(sys_clk),
        .issue_valid(w_iv), .issue_insn(w_insn),
        .first_source_reg(w_a), .second_source_reg(w_b));
    ssu_unit #(.XLEN(64)) i_dut_wide (.sys_clk(sys_clk), .rst(rst),
        .issue_valid(w_iv), .issue_insn(w_insn),
        .first_source_reg(w_a), .second_source_reg(w_b),
        .result_valid(w_rv), .result_data(w_data),
        .result_dest(w_dest), .not_claimed(w_nc));

    // ============================================================
    // reference values and encodings
    function automatic logic [31:0] rr(input logic [31:0] w, input int n);
        return (w >> n) | (w << (32 - n));
    endfunction
    function automatic logic [31:0] word_ref(input logic [4:0] sel,
            input logic [31:0] x);
        case (sel)
            5'h02: return rr(x, 7) ^ rr(x, 18) ^ (x >> 3);
            5'h03: return rr(x, 17) ^ rr(x, 19) ^ (x >> 10);
            5'h00: return rr(x, 2) ^ rr(x, 13) ^ rr(x, 22);
            default: return rr(x, 6) ^ rr(x, 11) ^ rr(x, 25);
        endcase
    endfunction
    // full 64-bit sigma0 of the wide hash
    function automatic logic [63:0] wsig0(input logic [63:0] x);
        return {x[0], x[63:1]} ^ {x[7:0], x[63:8]} ^ (x >> 7);
    endfunction
    function automatic ssu_pkg::ssu_insn_t mk_word(input logic [4:0] sel,
            input logic [4:0] rd);
        return '{ssu_pkg::F7_UNARY, sel, 5'h0A, ssu_pkg::F3_UNARY, rd,
            ssu_pkg::OPC_IMM};
    endfunction
    function automatic ssu_pkg::ssu_insn_t mk_half(input logic [6:0] f7,
            input logic [4:0] rd);
        return '{f7, 5'h0B, 5'h0A, ssu_pkg::F3_BINARY, rd, ssu_pkg::OPC_REG};
    endfunction

    // ============================================================
    // compares
    task automatic check_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic check_data(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t data %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_dest(input logic [4:0] got, input logic [4:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t dest %h exp %h", $time, got, exp);
        end
    endtask

    // ============================================================
    // drivers; wide upper source bits carry junk
    task automatic issue(input bit wide, input ssu_pkg::ssu_insn_t insn,
            input logic [31:0] a, input logic [31:0] b);
        if (wide) i_core_w.send(insn, {~a, a}, {~b, b});
        else i_core.send(insn, a, b);
    endtask
    task automatic idle(input bit wide);
        if (wide) i_core_w.idle();
        else i_core.idle();
    endtask
    // judge the answer to the issue sampled at the edge just passed
    task automatic expect_out(input bit wide, input logic claim,
            input logic [31:0] r, input logic [4:0] rd);
        logic [63:0] exp;
        exp = wide ? {{32{r[31]}}, r} : {32'h0, r};
        #1;
        if (wide) begin
            check_flag(w_rv, claim);
            check_flag(w_nc, !claim);
            check_data(w_data, exp);
            if (claim) check_dest(w_dest, rd);
        end else begin
            check_flag(n_rv, claim);
            check_flag(n_nc, !claim);
            check_data({32'h0, n_data}, exp);
            if (claim) check_dest(n_dest, rd);
        end
    endtask

    // all four word ops, boundary values, back to back
    task automatic run_words(input bit wide);
        logic [31:0] v[4];
        logic [31:0] pr;
        logic [4:0] s;
        v = '{32'h80000001, 32'hFFFFFFFF, 32'h00000000, 32'h12345678};
        for (int i = 0; i < 16; i++) begin
            s = 5'(i % 4);
            issue(wide, mk_word(s, 5'(i)), v[i / 4], ~v[i / 4]);
            if (i > 0) expect_out(wide, 1'b1, pr, 5'(i - 1));
            pr = word_ref(s, v[i / 4]);
        end
        idle(wide);
        expect_out(wide, 1'b1, pr, 5'h0F);
        idle(wide);
        #1;
        check_flag(wide ? w_rv : n_rv, 1'b0);
    endtask

    // ============================================================
    // scenarios
    task automatic t_word_ops();
        run_words(1'b0);
        $display("narrow word ops done");
    endtask
    task automatic t_wide();
        run_words(1'b1);
        $display("wide word ops done");
    endtask
    task automatic t_halves();
        logic [31:0] lo;
        logic [31:0] hi;
        logic [63:0] s;
        lo = 32'h89ABCDEF;
        hi = 32'h01234567;
        s = wsig0({hi, lo});
        issue(1'b0, mk_half(ssu_pkg::F7_WSIG0_LO, 5'h08), lo, hi);
        issue(1'b0, mk_half(ssu_pkg::F7_WSIG0_HI, 5'h09), hi, lo);
        expect_out(1'b0, 1'b1, s[31:0], 5'h08);
        idle(1'b0);
        expect_out(1'b0, 1'b1, s[63:32], 5'h09);
        $display("half ops done");
    endtask
    task automatic t_refused();
        issue(1'b1, mk_half(ssu_pkg::F7_WSIG0_HI, 5'h03), 32'h1, 32'h2);
        issue(1'b1, mk_half(ssu_pkg::F7_WSIG0_LO, 5'h04), 32'h1, 32'h2);
        expect_out(1'b1, 1'b0, 32'h0, 5'h0);
        idle(1'b1);
        expect_out(1'b1, 1'b0, 32'h0, 5'h0);
        issue(1'b0, mk_word(5'h04, 5'h05), 32'h1, 32'h2);
        issue(1'b0, mk_word(5'h1F, 5'h06), 32'h1, 32'h2);
        expect_out(1'b0, 1'b0, 32'h0, 5'h0);
        idle(1'b0);
        expect_out(1'b0, 1'b0, 32'h0, 5'h0);
        $display("refusals done");
    endtask

    // ============================================================
    // verdict
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // hang guard, far beyond the roughly 50 cycles of traffic
    initial begin
        #(1000 * 50);
        n_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_word_ops();
        t_wide();
        t_halves();
        t_refused();
        complete_run();
    end
endmodule
